// >>> rtl/igc_drive_phase.sv
// per-driver sequencer: charge pulse after a rising enable, then hold
module igc_drive_phase
  import igc_pkg::*;
#(
  parameter int PW = PULSE_W
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          enable_i,
  input  wire logic [PW-1:0] pulse_len_i,
  output logic               charge_o,
  output logic               hold_o
);
  igc_phase_t    state_r;
  igc_phase_t    state_nxt;
  logic [PW-1:0] cnt_r;
  logic [PW-1:0] cnt_nxt;

  generate
    if (PW < 1) begin : g_chk
      $error("igc_drive_phase: pulse width must be at least one");
    end
  endgenerate

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      PH_OFF: begin
        if (enable_i) begin
          state_nxt = (pulse_len_i == '0) ? PH_HOLD : PH_CHARGE;
          cnt_nxt   = pulse_len_i;
        end
      end
      PH_CHARGE: begin
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_r == PW'(1)) begin
          state_nxt = PH_HOLD;
        end
      end
      PH_HOLD: state_nxt = PH_HOLD;
      default: state_nxt = PH_OFF;
    endcase
    // sinking is immediate on a falling enable, no ramp
    if (!enable_i) begin
      state_nxt = PH_OFF;
      cnt_nxt   = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r  <= PH_OFF;
      cnt_r    <= '0;
      charge_o <= 1'b0;
      hold_o   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      charge_o <= (state_nxt == PH_CHARGE);
      hold_o   <= (state_nxt == PH_HOLD);
    end
  end
endmodule // igc_drive_phase

// >>> rtl/igc_gate_ctrl.sv
// gate enable control for five isolator drivers with a wishbone register port
// Functional notes
// - writing zero to charge pump enable stops pump; enabled drivers flag undervoltage
// - sleep mode forces the charge pump off regardless of its enable bit
// - rising latched enable starts a charge pulse of programmed length, then hold
// - falling latched enable sinks the gate at once, no turn-off ramp
// - common-drain configuration inverts reverse driver output polarity
// - each of the five drivers keeps its own latched enable
// - reset clears all latched enables and all command bits
// - protection inputs clear latched enables independently of serial commands
// - turn-on one with turn-off zero sets the latched enable, gate high
// - turn-on zero with turn-off one clears the latched enable, gate low
// - equal turn-on and turn-off bits leave the driver unchanged
// - command bits self-clear after acting and always read zero
// - each driver's bit pair is evaluated independently in one word
// - serial disable acts without delay, except current-gated reverse disable
// - with current gating, reverse disable waits until sensed current passes threshold
// - latched enables are readable as per-driver state flags
// - all ten command bits sit in the first enable/disable register
// - gates stay off until the charge pump is ready
// - drain config bit one selects common drain; zero, the default, common source
//
// Our own choices: the Wishbone register port and the address map.
module igc_gate_ctrl
  import igc_pkg::*;
#(
  parameter int PW = PULSE_W
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone classic slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // device-side inputs from outside this clock domain
  input  wire logic               sleep_i,
  input  wire logic               cp_ready_i,
  input  wire logic               neg_current_i,
  input  wire logic [NUM_DRV-1:0] protect_off_i,
  // driver control outputs
  output logic                    charge_pump_enable_o,
  output logic                    phase_u_gate_o,
  output logic                    phase_v_gate_o,
  output logic                    phase_w_gate_o,
  output logic                    bridge_gate_o,
  output logic                    reverse_gate_o,
  output logic      [NUM_DRV-1:0] charge_phase_o,
  output logic      [NUM_DRV-1:0] hold_phase_o,
  output logic      [NUM_DRV-1:0] gs_uv_fault_o
);
  generate
    if (PW < 1 || PW > PULSE_W) begin : g_chk
      $error("igc_gate_ctrl: pulse width out of range");
    end
  endgenerate

  // command field extraction, used only for command register write data
  function automatic igc_cmd_t cmd_of(input logic [31:0] d);
    igc_cmd_t c;
    c.turn_on  = d[CMD_ON_LSB +: NUM_DRV];
    c.turn_off = d[CMD_OFF_LSB +: NUM_DRV];
    return c;
  endfunction

  // ------------------------------------------------------------ synchronisers
  logic               sleep_s;
  logic               cp_ready_s;
  logic               neg_current_s;
  logic [NUM_DRV-1:0] protect_off_s;

  igc_sync #(
    .W (NUM_DRV + 3)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({protect_off_i, neg_current_i, cp_ready_i, sleep_i}),
    .q_o   ({protect_off_s, neg_current_s, cp_ready_s, sleep_s})
  );

  // ------------------------------------------------------------ bus decode
  logic        ack_r;
  logic [31:0] rdat_r;
  wire         bus_req  = wb_cyc_i && wb_stb_i && !ack_r;
  wire         bus_wr   = bus_req && wb_we_i;
  wire         hit_cmd  = (wb_adr_i == ADDR_CMD);
  wire         hit_cfg  = (wb_adr_i == ADDR_CFG);
  wire         hit_stat = (wb_adr_i == ADDR_STAT);
  // the ten command bits span byte lanes 0 and 1
  wire         cmd_wr   = bus_wr && hit_cmd && wb_sel_i[0] && wb_sel_i[1];
  wire         cfg_wr0  = bus_wr && hit_cfg && wb_sel_i[0];
  wire         cfg_wr1  = bus_wr && hit_cfg && wb_sel_i[1];

  // ------------------------------------------------------------ configuration
  igc_cfg_t cfg_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r.cp_en     <= CP_EN_RST;
      cfg_r.drain_cfg <= DRAIN_RST;
      cfg_r.idis      <= IDIS_RST;
      cfg_r.pulse     <= PULSE_W'(PW'(PULSE_DEF_CYC));
    end else begin
      if (cfg_wr0) begin
        cfg_r.cp_en     <= wb_dat_i[CFG_CP_EN];
        cfg_r.drain_cfg <= wb_dat_i[CFG_DRAIN];
        cfg_r.idis      <= wb_dat_i[CFG_IDIS];
      end
      if (cfg_wr1) begin
        cfg_r.pulse <= PULSE_W'(wb_dat_i[CFG_PULSE_LSB +: PW]);
      end
    end
  end

  // ------------------------------------------------------------ command evaluation
  // the command word acts only in its write cycle, so the bits never persist
  igc_cmd_t           cmd;
  logic [NUM_DRV-1:0] cmd_set;
  logic [NUM_DRV-1:0] cmd_clr;

  assign cmd     = cmd_wr ? cmd_of(wb_dat_i) : '0;
  // per-driver pair decode; equal bits give neither set nor clear
  assign cmd_set = cmd.turn_on & ~cmd.turn_off;
  assign cmd_clr = ~cmd.turn_on & cmd.turn_off;

  // ------------------------------------------------------------ latched enables
  logic [NUM_DRV-1:0] driver_latched_enable_r;
  logic [NUM_DRV-1:0] driver_latched_enable_nxt;
  logic               rev_pend_r;
  logic               rev_pend_nxt;
  logic               rev_gated;
  logic               rev_release;

  // reverse disable under current gating is deferred, not applied
  assign rev_gated   = cmd_clr[DRV_REV] && cfg_r.idis;
  // the gate releases once the sensed current passes the threshold,
  // or at once if gating has been switched off meanwhile; a turn-on in the
  // same cycle wins, so a fresh enable is never lost to the release
  assign rev_release = rev_pend_r && !cmd_set[DRV_REV]
                       && (neg_current_s || !cfg_r.idis);

  always_comb begin
    driver_latched_enable_nxt = driver_latched_enable_r;
    rev_pend_nxt              = rev_pend_r;
    for (int i = 0; i < NUM_DRV; i++) begin
      if (cmd_set[i]) begin
        driver_latched_enable_nxt[i] = 1'b1;
      end
      if (cmd_clr[i] && !(i == DRV_REV && cfg_r.idis)) begin
        driver_latched_enable_nxt[i] = 1'b0;
      end
    end
    if (rev_gated && driver_latched_enable_r[DRV_REV]) begin
      rev_pend_nxt = 1'b1;
    end
    if (rev_release) begin
      driver_latched_enable_nxt[DRV_REV] = 1'b0;
      rev_pend_nxt                       = 1'b0;
    end
    if (cmd_set[DRV_REV]) begin
      rev_pend_nxt = 1'b0;
    end
    // protection clears every affected enable whatever the command says
    for (int i = 0; i < NUM_DRV; i++) begin
      if (protect_off_s[i]) begin
        driver_latched_enable_nxt[i] = 1'b0;
      end
    end
    if (protect_off_s[DRV_REV]) begin
      rev_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      driver_latched_enable_r <= '0;
      rev_pend_r              <= 1'b0;
    end else begin
      driver_latched_enable_r <= driver_latched_enable_nxt;
      rev_pend_r              <= rev_pend_nxt;
    end
  end

  // ------------------------------------------------------------ charge pump
  wire pump_on = cfg_r.cp_en && !sleep_s;

  // ------------------------------------------------------------ drive phases
  // output stage is live only with the pump on and its voltage ready
  logic [NUM_DRV-1:0] drive_en;
  logic [NUM_DRV-1:0] charge_ph;
  logic [NUM_DRV-1:0] hold_ph;

  assign drive_en = driver_latched_enable_r & {NUM_DRV{cp_ready_s && pump_on}};

  for (genvar g = 0; g < NUM_DRV; g++) begin : g_drv
    igc_drive_phase #(
      .PW (PW)
    ) u_phase (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .enable_i    (drive_en[g]),
      .pulse_len_i (cfg_r.pulse[PW-1:0]),
      .charge_o    (charge_ph[g]),
      .hold_o      (hold_ph[g])
    );
  end

  // ------------------------------------------------------------ output registers
  wire rev_level = drive_en[DRV_REV] ^ cfg_r.drain_cfg;
  wire [NUM_DRV-1:0] uv_now = driver_latched_enable_r & {NUM_DRV{!pump_on}};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      charge_pump_enable_o <= 1'b0;
      phase_u_gate_o       <= 1'b0;
      phase_v_gate_o       <= 1'b0;
      phase_w_gate_o       <= 1'b0;
      bridge_gate_o        <= 1'b0;
      reverse_gate_o       <= 1'b0;
      charge_phase_o       <= '0;
      hold_phase_o         <= '0;
      gs_uv_fault_o        <= '0;
    end else begin
      charge_pump_enable_o <= pump_on;
      phase_u_gate_o       <= drive_en[DRV_U];
      phase_v_gate_o       <= drive_en[DRV_V];
      phase_w_gate_o       <= drive_en[DRV_W];
      bridge_gate_o        <= drive_en[DRV_BRG];
      reverse_gate_o       <= rev_level;
      charge_phase_o       <= charge_ph;
      hold_phase_o         <= hold_ph;
      gs_uv_fault_o        <= uv_now;
    end
  end

  // ------------------------------------------------------------ read mux
  logic [31:0] rd_cfg;
  logic [31:0] rd_stat;
  logic [31:0] rd_mux;

  always_comb begin
    rd_cfg                           = '0;
    rd_cfg[CFG_CP_EN]                = cfg_r.cp_en;
    rd_cfg[CFG_DRAIN]                = cfg_r.drain_cfg;
    rd_cfg[CFG_IDIS]                 = cfg_r.idis;
    rd_cfg[CFG_PULSE_LSB +: PW]      = cfg_r.pulse[PW-1:0];
    rd_stat                          = '0;
    rd_stat[ST_FLAG_LSB +: NUM_DRV]  = driver_latched_enable_r;
    rd_stat[ST_PEND]                 = rev_pend_r;
    rd_stat[ST_CP_RDY]               = cp_ready_s;
    rd_stat[ST_CP_ON]                = pump_on;
    rd_stat[ST_UV +: NUM_DRV]        = uv_now;
  end

  // command register always reads zero; unmapped addresses read zero
  assign rd_mux = hit_cfg  ? rd_cfg  :
                  hit_stat ? rd_stat : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= '0;
    end else begin
      ack_r  <= bus_req;
      if (bus_req && !wb_we_i) begin
        rdat_r <= rd_mux;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
endmodule // igc_gate_ctrl

// >>> rtl/igc_pkg.sv
// package: register map, field layout, timing and types of the gate enable control
package igc_pkg;
  localparam int          NUM_DRV       = 5;
  // driver index order inside every five-bit field
  localparam int          DRV_U         = 0;
  localparam int          DRV_V         = 1;
  localparam int          DRV_W         = 2;
  localparam int          DRV_BRG       = 3;
  localparam int          DRV_REV       = 4;
  // wishbone byte addresses
  localparam logic [7:0]  ADDR_CMD      = 8'h00;
  localparam logic [7:0]  ADDR_CFG      = 8'h04;
  localparam logic [7:0]  ADDR_STAT     = 8'h08;
  // command register fields
  localparam int          CMD_ON_LSB    = 0;
  localparam int          CMD_OFF_LSB   = 5;
  // configuration register fields
  localparam int          CFG_CP_EN     = 0;
  localparam int          CFG_DRAIN     = 1;
  localparam int          CFG_IDIS      = 2;
  localparam int          CFG_PULSE_LSB = 8;
  localparam int          PULSE_W       = 8;
  // status register fields
  localparam int          ST_FLAG_LSB   = 0;
  localparam int          ST_PEND       = 5;
  localparam int          ST_CP_RDY     = 6;
  localparam int          ST_CP_ON      = 7;
  localparam int          ST_UV         = 8;
  // timing
  localparam int          CLK_NS        = 100;
  localparam int          PULSE_DEF_NS  = 2000;
  localparam int          PULSE_DEF_CYC = (PULSE_DEF_NS + CLK_NS - 1) / CLK_NS;
  // reset values
  localparam logic        CP_EN_RST     = 1'b1;
  localparam logic        DRAIN_RST     = 1'b0;
  localparam logic        IDIS_RST      = 1'b0;

  typedef struct packed {
    logic [NUM_DRV-1:0] turn_off;
    logic [NUM_DRV-1:0] turn_on;
  } igc_cmd_t;

  typedef struct packed {
    logic               cp_en;
    logic               drain_cfg;
    logic               idis;
    logic [PULSE_W-1:0] pulse;
  } igc_cfg_t;

  typedef enum logic [1:0] {
    PH_OFF    = 2'b00,
    PH_CHARGE = 2'b01,
    PH_HOLD   = 2'b10
  } igc_phase_t;
endpackage : igc_pkg

// >>> rtl/igc_sync.sv
// two flip-flop synchroniser for a group of level inputs
module igc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  generate
    if (W < 1) begin : g_chk
      $error("igc_sync: width must be at least one");
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule // igc_sync

// >>> tb/igc_gate_ctrl_sva.sv
// checker: port-level timing relations of the gate enable control
module igc_chk
  import igc_pkg::*;
(
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic [7:0]         wb_adr_i,
  input wire logic [3:0]         wb_sel_i,
  input wire logic [31:0]        wb_dat_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic               wb_ack_o,
  input wire logic               sleep_i,
  input wire logic               cp_ready_i,
  input wire logic [NUM_DRV-1:0] protect_off_i,
  input wire logic               charge_pump_enable_o,
  input wire logic               phase_u_gate_o,
  input wire logic [NUM_DRV-1:0] charge_phase_o,
  input wire logic [NUM_DRV-1:0] hold_phase_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire cmd_wr = req & wb_we_i & (wb_adr_i == ADDR_CMD) & (&wb_sel_i[1:0]);
  ack_once_a: assert property (
    req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not a single pulse");
  cmd_zero_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i != ADDR_CFG && wb_adr_i != ADDR_STAT
    |-> wb_dat_o == 32'h0) else $error("command or unmapped read not zero");
  off_now_a: assert property (
    cmd_wr && wb_dat_i[5] && !wb_dat_i[0] |-> ##2 !phase_u_gate_o)
    else $error("gate not off after turn-off");
  on_now_a: assert property (
    cmd_wr && wb_dat_i[0] && !wb_dat_i[5] && !protect_off_i[0]
    |-> ##3 (charge_phase_o[0] || hold_phase_o[0])) else $error("driver not on");
  phase_excl_a: assert property (
    charge_phase_o[0] |-> !hold_phase_o[0]) else $error("charge and hold together");
  sleep_off_a: assert property (
    sleep_i[*4] |-> !charge_pump_enable_o) else $error("pump runs in sleep");
  pump_gate_a: assert property (
    !charge_pump_enable_o[*3] |-> !phase_u_gate_o) else $error("gate on with pump off");
  ready_gate_a: assert property (
    !cp_ready_i[*5] |-> !phase_u_gate_o) else $error("gate on before pump ready");
  protect_a: assert property (
    protect_off_i[0][*5] |-> !phase_u_gate_o) else $error("protection did not clear");
endmodule // igc_chk

// >>> tb/igc_host_model.sv
// host model: classic wishbone master issuing driver commands
module igc_host
  import igc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [31:0]      dat_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cyc_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    dat_o = 32'h0;
  end
  // called right after a rising edge; holds the request until ack is seen
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    cyc_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    @(posedge clk_i);
    // no cycle count is assumed; only the bench watchdog ends a wait
    while (ack_i !== 1'b1) begin
      @(posedge clk_i);
    end
    q = dat_i;
    cyc_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule // igc_host

// >>> tb/test_isolator_gate_enable_control.sv
// testbench: command table, pulse timing, gated reverse, pump, protection, reset
module test_isolator_gate_enable_control
  import igc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               sleep_i = 1'b0;
  logic               cp_ready_i = 1'b0;
  logic               neg_current_i = 1'b0;
  logic [NUM_DRV-1:0] protect_off_i = '0;
  logic [3:0]         sel = 4'hf;
  logic               cyc, we, ack, cpe, gu, gv, gw, gb, gr;
  logic [7:0]         adr;
  logic [31:0]        wdat, rdat, q;
  logic [NUM_DRV-1:0] chg, hld, uv;
  logic [4:0]         gates;
  int                 errors = 0;
  int                 compares = 0;
  int                 n;
  // each row: ten command bits, then the expected latched enables
  logic [14:0]        rows [6] = '{{10'h01f, 5'h1f}, {10'h060, 5'h1c}, {10'h0a1, 5'h18},
                                   {10'h103, 5'h13}, {10'h3ff, 5'h13}, {10'h3e0, 5'h00}};
  assign gates = {gr, gb, gw, gv, gu};
  igc_host i_host (.clk_i, .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .we_o(we),
                   .adr_o(adr), .dat_o(wdat));
  igc_gate_ctrl i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sleep_i, .cp_ready_i, .neg_current_i, .protect_off_i, .charge_pump_enable_o(cpe),
    .phase_u_gate_o(gu), .phase_v_gate_o(gv), .phase_w_gate_o(gw), .bridge_gate_o(gb),
    .reverse_gate_o(gr), .charge_phase_o(chg), .hold_phase_o(hld), .gs_uv_fault_o(uv));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    errors++;
    wrap_up();
  end
  initial begin
    tick(16);
    rst_i <= 1'b0;
    cp_ready_i <= 1'b1;
    tick(6);
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CMD, {22'h0, rows[i][14:5]});
      tick(3);
      chk({27'h0, gates}, {27'h0, rows[i][4:0]});
      rd(ADDR_STAT);
      chk({27'h0, q[4:0]}, {27'h0, rows[i][4:0]});
      rd(ADDR_CMD);
      chk(q, 32'h0);
    end
    $display("test table done");
    wr(ADDR_CFG, 32'h0000_0301);
    wr(ADDR_CMD, 32'h0000_0001);
    n = 0;
    repeat (12) begin
      @(posedge clk_i);
      if (chg[0] === 1'b1) n++;
    end
    chk(32'(n), 32'h3);
    chk({27'h0, hld}, 32'h1);
    chk({27'h0, chg}, 32'h0);
    $display("test pulse done");
    wr(ADDR_CFG, 32'h0000_0305);
    wr(ADDR_CMD, 32'h0000_0010);
    wr(ADDR_CMD, 32'h0000_0200);
    tick(4);
    rd(ADDR_STAT);
    chk({31'h0, q[5]}, 32'h1);
    chk({31'h0, gr}, 32'h1);
    wr(ADDR_CMD, 32'h0000_0010);
    rd(ADDR_STAT);
    chk({31'h0, q[5]}, 32'h0);
    wr(ADDR_CMD, 32'h0000_0200);
    neg_current_i <= 1'b1;
    tick(6);
    chk({31'h0, gr}, 32'h0);
    neg_current_i <= 1'b0;
    wr(ADDR_CFG, 32'h0000_0303);
    tick(2);
    chk({31'h0, gr}, 32'h1);
    $display("test reverse done");
    sleep_i <= 1'b1;
    tick(6);
    chk({30'h0, cpe, gu}, 32'h0);
    chk({27'h0, uv}, 32'h1);
    sleep_i <= 1'b0;
    tick(6);
    chk({31'h0, cpe}, 32'h1);
    wr(ADDR_CFG, 32'h0000_0300);
    tick(4);
    chk({30'h0, cpe, gu}, 32'h0);
    wr(ADDR_CFG, 32'h0000_0301);
    protect_off_i <= 5'h01;
    tick(6);
    rd(ADDR_STAT);
    chk({31'h0, q[0]}, 32'h0);
    protect_off_i <= 5'h00;
    rd(8'hfc);
    chk(q, 32'h0);
    $display("test pump and protect done");
    wr(ADDR_CMD, 32'h0000_0001);
    cp_ready_i <= 1'b0;
    tick(6);
    chk({27'h0, gates}, 32'h0);
    rd(ADDR_STAT);
    chk({27'h0, q[4:0]}, 32'h1);
    cp_ready_i <= 1'b1;
    // byte lane 1 missing: the turn-off bit of phase u must be ignored
    sel <= 4'hd;
    wr(ADDR_CMD, 32'h0000_0020);
    sel <= 4'hf;
    rd(ADDR_STAT);
    chk({27'h0, q[4:0]}, 32'h1);
    $display("test ready and lanes done");
    wr(ADDR_CMD, 32'h0000_001f);
    rst_i <= 1'b1;
    tick(3);
    rst_i <= 1'b0;
    tick(1);
    chk({27'h0, gates}, 32'h0);
    rd(ADDR_STAT);
    chk({27'h0, q[4:0]}, 32'h0);
    rd(ADDR_CFG);
    chk(q, 32'h0000_1401);
    $display("test reset done");
    wrap_up();
  end
endmodule // test_isolator_gate_enable_control

bind igc_gate_ctrl igc_chk i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sleep_i, .cp_ready_i,
  .protect_off_i, .charge_pump_enable_o, .phase_u_gate_o, .charge_phase_o, .hold_phase_o);
